//--- verilog/in_ep_desc_pkg.sv
package in_ep_desc_pkg;
    // Register indices; byte address is four times the index
    localparam int unsigned    ADDR_W           = 18;
    localparam logic [15:0]    IDX_EP0_IN_CFG   = 16'hFF80;
    localparam logic [15:0]    IDX_EP0_IN_CNT   = 16'hFF81;
    localparam logic [15:0]    IDX_EP0_OUT_CFG  = 16'hFF82;
    localparam logic [15:0]    IDX_EP0_OUT_CNT  = 16'hFF83;
    localparam logic [15:0]    IDX_Y_BASE_GRP   = 16'h0010;
    localparam logic [15:0]    IDX_Y_COUNT_GRP  = 16'h0020;
    localparam logic [15:0]    IDX_SIZE_GRP     = 16'h0030;
    localparam logic [15:0]    IDX_IRQ_STATUS   = 16'h0040;
    localparam logic [15:0]    IDX_IRQ_MASK     = 16'h0041;
    // Field positions of the endpoint-0 registers; only the NAK position is also used by endpoints 1 to 3
    localparam int unsigned    BIT_ENABLE       = 7;
    localparam int unsigned    BIT_TOGGLE       = 5;
    localparam int unsigned    BIT_STALL        = 3;
    localparam int unsigned    BIT_IRQ_EN       = 2;
    localparam int unsigned    BIT_NAK          = 7;
    // Fixed endpoint-0 buffers
    localparam logic [15:0]    EP0_IN_BUF_ADDR  = 16'hFEF8;
    localparam logic [15:0]    EP0_OUT_BUF_ADDR = 16'hFEF0;
    localparam logic [3:0]     EP0_COUNT_MAX    = 4'h8;
    localparam logic [2:0]     BASE_PAD         = 3'h0;
    localparam logic [4:0]     ADDR_EXT         = 5'h00;
    localparam logic [7:0]     COUNT_RESET      = 8'h80;
    localparam logic [1:0]     RESP_OKAY        = 2'h0;
    localparam logic [1:0]     RESP_DECERR      = 2'h3;
endpackage

//--- verilog/usb_in_endpoint_descriptors.sv
// Operation
// R01: Buffer start address is eight stored bits with three zero bits appended.
// R02: Each transaction starts at the programmed base address written by firmware.
// R03: Transaction completion never alters the stored base address.
// R04: Firmware keeps byte counts at 64 or below; larger codes are undefined.
// R05: NAK clear means packet ready; NAK set means empty, host gets NAK.
// R06: Seven-bit read/write buffer size per endpoint; top bit reads zero.
// R07: Four endpoint-0 registers sit at consecutive indices from FF80.
// R08: Endpoint-0 buffers are fixed at FEF8 (input) and FEF0 (output).
// R09: Endpoint-0 fields keep the same bit positions; others reserved.
// R10: Interrupt enable bit 2 gates completion interrupt; resets to zero.
// R11: Stall bit 3 answers STALL; cleared by next setup transaction.
// R12: Read-only bit 5 shows endpoint-0 data toggle; resets to zero.
// R13: Enable bit 7 clear stops buffer manager serving endpoint-0 input.
// R14: Endpoint-0 count is four bits, reset zero, largest valid code eight.
// R15: Reserved bits read zero and ignore writes.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module usb_in_endpoint_descriptors
    import in_ep_desc_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic [1:0]          bm_ep_sel,
    input  wire logic                bm_in_done,
    input  wire logic                setup_received,
    output logic [15:0]              sel_buf_addr,
    output logic [6:0]               sel_byte_count,
    output logic                     sel_nak,
    output logic                     sel_stall,
    output logic                     sel_toggle,
    output logic                     sel_enable,
    output logic [15:0]              ep0_out_buf_addr,
    output logic                     irq
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // =========================================================
    // Helpers
    // =========================================================
    function automatic logic [1:0] group_ep(input logic [15:0] idx,
                                            input logic [15:0] grp);
        group_ep = (idx[15:2] == grp[15:2]) ? idx[1:0] : 2'h0;
    endfunction
    function automatic logic [3:0] ep0_count_sat(input logic [3:0] c);
        ep0_count_sat = (c > EP0_COUNT_MAX) ? EP0_COUNT_MAX : c;
    endfunction
    // =========================================================
    // State
    // =========================================================
    logic [7:0]          y_base   [1:3];
    logic [7:0]          y_count  [1:3];
    logic [6:0]          buf_size [1:3];
    logic                ep0_enable;
    logic                ep0_stall;
    logic                ep0_irq_en;
    logic                ep0_toggle;
    logic                ep0_nak;
    logic [3:0]          ep0_count;
    logic                out_enable;
    logic                out_stall;
    logic                out_irq_en;
    logic                out_nak;
    logic [3:0]          out_count;
    logic [3:0]          irq_status;
    logic [3:0]          irq_mask;
    logic                aw_full;
    logic                w_full;
    logic [15:0]         aw_idx;
    logic [7:0]          w_byte;
    logic                w_lane0;
    // =========================================================
    // Write channel decode
    // =========================================================
    wire                 wr_go     = aw_full && w_full && !s_axi_bvalid;
    wire                 wr_en     = wr_go && w_lane0;
    wire [1:0]           wr_base   = group_ep(aw_idx, IDX_Y_BASE_GRP);
    wire [1:0]           wr_ycnt   = group_ep(aw_idx, IDX_Y_COUNT_GRP);
    wire [1:0]           wr_size   = group_ep(aw_idx, IDX_SIZE_GRP);
    wire                 wr_in_cfg = wr_en && aw_idx == IDX_EP0_IN_CFG; // [R07]
    wire                 wr_in_cnt = wr_en && aw_idx == IDX_EP0_IN_CNT;
    wire                 wr_o_cfg  = wr_en && aw_idx == IDX_EP0_OUT_CFG;
    wire                 wr_o_cnt  = wr_en && aw_idx == IDX_EP0_OUT_CNT;
    wire                 wr_status = wr_en && aw_idx == IDX_IRQ_STATUS;
    wire                 wr_mask   = wr_en && aw_idx == IDX_IRQ_MASK;
    wire                 wr_mapped = aw_idx == IDX_EP0_IN_CFG
                                  || aw_idx == IDX_EP0_IN_CNT
                                  || aw_idx == IDX_EP0_OUT_CFG
                                  || aw_idx == IDX_EP0_OUT_CNT
                                  || aw_idx == IDX_IRQ_STATUS
                                  || aw_idx == IDX_IRQ_MASK
                                  || wr_base != 2'h0
                                  || wr_ycnt != 2'h0
                                  || wr_size != 2'h0;
    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready  = !w_full && !s_axi_bvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            aw_idx       <= 16'h0000;
            w_byte       <= 8'h00;
            w_lane0      <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full <= 1'b1;
                aw_idx  <= s_axi_awaddr[ADDR_W-1:2];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full  <= 1'b1;
                w_byte  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (wr_go)
            begin
                aw_full      <= 1'b0;
                w_full       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_DECERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // =========================================================
    // Buffer manager events
    // =========================================================
    // Endpoint-0 completions are ignored while its enable is clear
    wire                 ep0_done  = bm_in_done && bm_ep_sel == 2'h0
                                  && ep0_enable; // [R13]
    wire [3:0]           done_vec  = {bm_in_done && bm_ep_sel == 2'h3,
                                      bm_in_done && bm_ep_sel == 2'h2,
                                      bm_in_done && bm_ep_sel == 2'h1,
                                      ep0_done && ep0_irq_en}; // [R10]
    wire [3:0]           clr_vec   = wr_status ? w_byte[3:0] : 4'h0;
    // Setting by software beats the automatic clear in the same cycle
    wire                 next_stall = wr_in_cfg ? w_byte[BIT_STALL]
                                  : (setup_received ? 1'b0 : ep0_stall);
    wire                 next_ostall = wr_o_cfg ? w_byte[BIT_STALL]
                                  : (setup_received ? 1'b0 : out_stall);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ep0_enable <= 1'b0;
            ep0_stall  <= 1'b0;
            ep0_irq_en <= 1'b0;
            ep0_toggle <= 1'b0;
            ep0_nak    <= 1'b1;
            ep0_count  <= 4'h0;
            out_enable <= 1'b0;
            out_stall  <= 1'b0;
            out_irq_en <= 1'b0;
            out_nak    <= 1'b1;
            out_count  <= 4'h0;
            irq_status <= 4'h0;
            irq_mask   <= 4'h0;
        end
        else
        begin
            if (wr_in_cfg)
            begin
                ep0_enable <= w_byte[BIT_ENABLE];
                ep0_irq_en <= w_byte[BIT_IRQ_EN];
            end
            ep0_stall <= next_stall; // [R11]
            if (ep0_done)
                ep0_toggle <= !ep0_toggle; // [R12]
            if (wr_in_cnt)
                ep0_count <= w_byte[3:0]; // [R14]
            // Completion marks the buffer empty, beating a firmware clear
            if (ep0_done)
                ep0_nak <= 1'b1; // [R05]
            else if (wr_in_cnt)
                ep0_nak <= w_byte[BIT_NAK];
            if (wr_o_cfg)
            begin
                out_enable <= w_byte[BIT_ENABLE];
                out_irq_en <= w_byte[BIT_IRQ_EN];
            end
            out_stall <= next_ostall;
            if (wr_o_cnt)
            begin
                out_nak   <= w_byte[BIT_NAK];
                out_count <= w_byte[3:0];
            end
            if (wr_mask)
                irq_mask <= w_byte[3:0];
            irq_status <= (irq_status & ~clr_vec) | done_vec;
        end
    end
    // Firmware owns the base address; completion touches only the count
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int n = 1; n <= 3; n++)
            begin
                y_base[n]   <= 8'h00;
                y_count[n]  <= COUNT_RESET;
                buf_size[n] <= 7'h00;
            end
        end
        else
        begin
            for (int n = 1; n <= 3; n++)
            begin
                if (wr_en && wr_base == 2'(n))
                    y_base[n] <= w_byte; // [R03]
                if (bm_in_done && bm_ep_sel == 2'(n))
                    y_count[n][BIT_NAK] <= 1'b1; // [R05]
                else if (wr_en && wr_ycnt == 2'(n))
                    y_count[n] <= w_byte; // [R04]
                if (wr_en && wr_size == 2'(n))
                    buf_size[n] <= w_byte[6:0]; // [R06]
            end
        end
    end
    assign irq = |(irq_status & irq_mask);
    // =========================================================
    // Selected endpoint view for the buffer manager
    // =========================================================
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sel_buf_addr   <= EP0_IN_BUF_ADDR;
            sel_byte_count <= 7'h00;
            sel_nak        <= 1'b1;
            sel_stall      <= 1'b0;
            sel_toggle     <= 1'b0;
            sel_enable     <= 1'b0;
        end
        else if (bm_ep_sel == 2'h0)
        begin
            sel_buf_addr   <= EP0_IN_BUF_ADDR; // [R08]
            sel_byte_count <= {3'h0, ep0_count_sat(ep0_count)}; // [R14]
            sel_nak        <= ep0_nak;
            sel_stall      <= ep0_stall;
            sel_toggle     <= ep0_toggle;
            sel_enable     <= ep0_enable; // [R13]
        end
        else
        begin
            sel_buf_addr   <= {ADDR_EXT, y_base[bm_ep_sel], BASE_PAD}; // [R01] [R02]
            sel_byte_count <= y_count[bm_ep_sel][6:0];
            sel_nak        <= y_count[bm_ep_sel][BIT_NAK];
            sel_stall      <= 1'b0;
            sel_toggle     <= 1'b0;
            sel_enable     <= 1'b1;
        end
    end
    assign ep0_out_buf_addr = EP0_OUT_BUF_ADDR; // [R08]
    // =========================================================
    // Read channel
    // =========================================================
    wire [15:0]          rd_idx  = s_axi_araddr[ADDR_W-1:2];
    wire [1:0]           rd_base = group_ep(rd_idx, IDX_Y_BASE_GRP);
    wire [1:0]           rd_ycnt = group_ep(rd_idx, IDX_Y_COUNT_GRP);
    wire [1:0]           rd_size = group_ep(rd_idx, IDX_SIZE_GRP);
    // Reserved positions are wired to zero
    wire [7:0]           in_cfg  = {ep0_enable, 1'b0, ep0_toggle, 1'b0,
                                    ep0_stall, ep0_irq_en, 2'h0}; // [R09] [R15]
    wire [7:0]           in_cnt  = {ep0_nak, 3'h0, ep0_count}; // [R15]
    wire [7:0]           o_cfg   = {out_enable, 1'b0, 1'b0, 1'b0,
                                    out_stall, out_irq_en, 2'h0}; // [R09]
    wire [7:0]           o_cnt   = {out_nak, 3'h0, out_count};
    wire                 rd_hit  = rd_idx == IDX_EP0_IN_CFG
                                || rd_idx == IDX_EP0_IN_CNT
                                || rd_idx == IDX_EP0_OUT_CFG
                                || rd_idx == IDX_EP0_OUT_CNT
                                || rd_idx == IDX_IRQ_STATUS
                                || rd_idx == IDX_IRQ_MASK
                                || rd_base != 2'h0
                                || rd_ycnt != 2'h0
                                || rd_size != 2'h0;
    wire [7:0]           rd_byte =
        rd_idx == IDX_EP0_IN_CFG  ? in_cfg :
        rd_idx == IDX_EP0_IN_CNT  ? in_cnt :
        rd_idx == IDX_EP0_OUT_CFG ? o_cfg :
        rd_idx == IDX_EP0_OUT_CNT ? o_cnt :
        rd_idx == IDX_IRQ_STATUS  ? {4'h0, irq_status} :
        rd_idx == IDX_IRQ_MASK    ? {4'h0, irq_mask} :
        rd_base != 2'h0           ? y_base[rd_base] :
        rd_ycnt != 2'h0           ? y_count[rd_ycnt] :
        rd_size != 2'h0           ? {1'b0, buf_size[rd_size]} : // [R06]
                                    8'h00;
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_DECERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end
    // =========================================================
    // Checks
    // =========================================================
    a_nak_on_done: assert property ( // [R05]
        bm_in_done && bm_ep_sel != 2'h0 |=> y_count[$past(bm_ep_sel)][BIT_NAK])
        else $error("NAK not set after completion");
    a_base_kept: assert property ( // [R03]
        bm_in_done && !wr_en |=> $stable(y_base[1]) && $stable(y_base[2])
                                 && $stable(y_base[3]))
        else $error("base address changed by completion");
    a_addr_format: assert property ( // [R01]
        bm_ep_sel != 2'h0 |=> sel_buf_addr ==
            {ADDR_EXT, $past(y_base[bm_ep_sel]), BASE_PAD})
        else $error("buffer address not base with zero pad");
    a_ep0_addr: assert property ( // [R08]
        bm_ep_sel == 2'h0 ##1 1'b1 |-> sel_buf_addr == EP0_IN_BUF_ADDR)
        else $error("endpoint-0 buffer address wrong");
    a_toggle_flip: assert property ( // [R12]
        ep0_done |=> ep0_toggle != $past(ep0_toggle))
        else $error("toggle did not flip on completion");
    a_disabled_ignored: assert property ( // [R13]
        !ep0_enable && bm_ep_sel == 2'h0 |=> $stable(ep0_toggle)
            && !irq_status[0] || $past(irq_status[0]))
        else $error("disabled endpoint-0 was served");
    a_irq_gate: assert property ( // [R10]
        !irq_status[0] && !(ep0_done && ep0_irq_en) |=> !irq_status[0])
        else $error("endpoint-0 interrupt without enable");
    a_stall_clear: assert property ( // [R11]
        setup_received && !wr_in_cfg |=> !ep0_stall
            ##1 (ep0_stall -> $past(wr_in_cfg)))
        else $error("stall not cleared by setup");
    a_count_sat: assert property ( // [R14]
        bm_ep_sel == 2'h0 |=> sel_byte_count <= 7'(EP0_COUNT_MAX))
        else $error("endpoint-0 count above eight");
    a_irq_level: assert property ( // [R10]
        ep0_done && ep0_irq_en |=> irq_status[0])
        else $error("endpoint-0 completion interrupt lost");
endmodule // usb_in_endpoint_descriptors

//--- verification/usb_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Buffer manager and host side of IN traffic
module usb_host_model
(
    input  wire logic       aclk,
    input  wire logic       sel_nak,
    input  wire logic       sel_enable,
    output logic [1:0]      bm_ep_sel,
    output logic            bm_in_done,
    output logic            setup_received
);
    initial
    begin
        bm_ep_sel = 2'h0;
        bm_in_done = 1'b0;
        setup_received = 1'b0;
    end
    // Point at an endpoint, finish one IN after a gap
    task automatic serve(input logic [1:0] ep, input int gap,
                         input bit force_done);
        @(posedge aclk);
        bm_ep_sel <= ep;
        repeat (gap + 2) @(posedge aclk);
        // Empty or disabled buffer without force_done: host only saw NAK
        if (force_done || (!sel_nak && sel_enable))
        begin
            bm_in_done <= 1'b1;
            @(posedge aclk);
            bm_in_done <= 1'b0;
        end
        @(posedge aclk);
    endtask
    task automatic setup();
        @(posedge aclk);
        setup_received <= 1'b1;
        @(posedge aclk);
        setup_received <= 1'b0;
        @(posedge aclk);
    endtask
endmodule // usb_host_model

//--- verification/testbench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
    errors++; $display("BAD %0t got %h exp %h", $time, got, exp); end end
module testbench;
    import in_ep_desc_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp, bm_ep_sel;
    logic bm_in_done, setup_received, sel_nak, sel_stall;
    logic sel_toggle, sel_enable;
    logic [15:0] sel_buf_addr, ep0_out_buf_addr;
    logic [6:0] sel_byte_count, c;
    logic [7:0] b, d;
    int errors = 0;
    int cmp_count = 0;
    int seed = 32'h5a0818f6;
    logic [15:0] rix [7] = '{16'hFF80, 16'hFF81, 16'hFF82, 16'hFF83,
                             16'h0011, 16'h0021, 16'h0031};
    logic [7:0] rst [7] = '{8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00};

    usb_in_endpoint_descriptors uut
    (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .bm_ep_sel(bm_ep_sel), .bm_in_done(bm_in_done),
        .setup_received(setup_received), .sel_buf_addr(sel_buf_addr),
        .sel_byte_count(sel_byte_count), .sel_nak(sel_nak),
        .sel_stall(sel_stall), .sel_toggle(sel_toggle),
        .sel_enable(sel_enable), .ep0_out_buf_addr(ep0_out_buf_addr),
        .irq(irq)
    );
    usb_host_model host
    (
        .aclk(aclk), .sel_nak(sel_nak), .sel_enable(sel_enable),
        .bm_ep_sel(bm_ep_sel), .bm_in_done(bm_in_done),
        .setup_received(setup_received)
    );
    // ==========================================
    // Clock, verdict and bus tasks
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    task automatic finish_test();
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] v);
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] idx);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    function automatic logic [31:0] exp_rd(input logic [15:0] i,
                                           input logic [7:0] v);
        case (i)
            IDX_EP0_IN_CFG, IDX_EP0_OUT_CFG: exp_rd = {24'h0, v & 8'h8C};
            IDX_EP0_IN_CNT, IDX_EP0_OUT_CNT: exp_rd = {24'h0, v & 8'h8F};
            default: exp_rd = {24'h0, (i[5:4] == 2'h3) ? v & 8'h7F : v};
        endcase
    endfunction
    // ==========================================
    // Main sequence
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, aresetn} = 3'h0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        `CHK(sel_buf_addr, EP0_IN_BUF_ADDR);
        `CHK(ep0_out_buf_addr, EP0_OUT_BUF_ADDR);
        `CHK(sel_nak, 1'b1);
        for (int k = 0; k < 7; k++)
        begin
            rd(rix[k]);
            `CHK(rdat, {24'h0, rst[k]});
            `CHK(resp, RESP_OKAY);
        end
        for (int k = 0; k < 21; k++)
        begin
            d = (k < 7) ? 8'hFF : 8'($random(seed));
            if (rix[k % 7][5:4] == 2'h2)
                d[6:0] = (k < 7) ? 7'h40 : 7'(d[6:0] % 65);
            wr(rix[k % 7], d);
            rd(rix[k % 7]);
            `CHK(rdat, exp_rd(rix[k % 7], d));
        end
        rd(16'h0050);
        `CHK(resp, RESP_DECERR);
        wr(16'h0050, 8'hFF);
        `CHK(resp, RESP_DECERR);
        s_axi_wstrb <= 4'hE;
        wr(IDX_IRQ_MASK, 8'h0F);
        s_axi_wstrb <= 4'hF;
        rd(IDX_IRQ_MASK);
        `CHK(rdat, 32'h0);
        wr(IDX_IRQ_MASK, 8'h0F);
        for (int n = 1; n < 4; n++)
        begin
            b = 8'($random(seed));
            c = (n == 3) ? 7'h40 : 7'($unsigned($random(seed)) % 64);
            wr(16'(IDX_Y_BASE_GRP + n), b);
            wr(16'(IDX_Y_COUNT_GRP + n), {1'b0, c});
            host.serve(2'(n), n - 1, 1'b0);
            @(negedge aclk);
            `CHK(sel_buf_addr, {5'h00, b, 3'h0});
            `CHK(sel_byte_count, c);
            `CHK(sel_nak, 1'b1);
            `CHK(irq, 1'b1);
            rd(16'(IDX_Y_BASE_GRP + n));
            `CHK(rdat, {24'h0, b});
            wr(IDX_IRQ_MASK, 8'h00);
            @(negedge aclk);
            `CHK(irq, 1'b0);
            wr(IDX_IRQ_MASK, 8'h0F);
            wr(IDX_IRQ_STATUS, 8'(1 << n));
            @(negedge aclk);
            `CHK(irq, 1'b0);
        end
        wr(IDX_EP0_IN_CFG, 8'h04);
        host.serve(2'h0, 0, 1'b1);
        rd(IDX_EP0_IN_CFG);
        `CHK(rdat, 32'h04);
        `CHK(irq, 1'b0);
        wr(IDX_EP0_IN_CFG, 8'h84);
        wr(IDX_EP0_IN_CNT, 8'h0F);
        @(negedge aclk);
        `CHK(sel_byte_count, 7'h08);
        `CHK(sel_buf_addr, EP0_IN_BUF_ADDR);
        host.serve(2'h0, 1, 1'b0);
        @(negedge aclk);
        `CHK(sel_toggle, 1'b1);
        `CHK(irq, 1'b1);
        rd(IDX_EP0_IN_CNT);
        `CHK(rdat, 32'h8F);
        wr(IDX_IRQ_STATUS, 8'h01);
        wr(IDX_EP0_IN_CFG, 8'h80);
        wr(IDX_EP0_IN_CNT, 8'h07);
        host.serve(2'h0, 2, 1'b0);
        rd(IDX_EP0_IN_CFG);
        `CHK(rdat, 32'h80);
        `CHK(irq, 1'b0);
        wr(IDX_EP0_IN_CFG, 8'h88);
        @(negedge aclk);
        `CHK(sel_stall, 1'b1);
        host.setup();
        rd(IDX_EP0_IN_CFG);
        `CHK(rdat, 32'h80);
        finish_test();
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        errors++;
        finish_test();
    end
endmodule // testbench
